/* ns_fmt_defines.svh */
// Purpose: Offsets, field positions and reset values of the namespace format registers
// Assumes: Word index = byte address / 4
// Notes:   Definitions only
`ifndef NS_FMT_DEFINES_SVH
`define NS_FMT_DEFINES_SVH
// ==========================================================
// Register indices (byte address = 4 * index)
`define IDX_NS_SIZE      7'h00
`define IDX_NS_CAP       7'h02
`define IDX_NS_USE       7'h04
`define IDX_FEAT         7'h18
`define IDX_FMT_COUNT    7'h19
`define IDX_FMT_SEL      7'h1a
`define IDX_MD_CAP       7'h1b
`define IDX_PROT_CAP     7'h1c
`define IDX_ADVICE       7'h1d
`define IDX_CFG_SIZE     7'h40
`define IDX_CFG_CAP      7'h41
`define IDX_CFG_FEAT     7'h42
`define IDX_CFG_FMT      7'h43
`define IDX_CFG_MD       7'h44
`define IDX_CFG_PROT     7'h45
`define TBL_RD_BASE      3'h2
`define TBL_WR_BASE      3'h6
// ==========================================================
// Field positions
`define FEAT_THIN_BIT    0
`define CFG_DEALLOC_BIT  8
`define CFG_FMT_CNT_LSB  0
`define CFG_FMT_SEL_LSB  8
`define CFG_FMT_EXT_BIT  16
`define SEL_EXT_BIT      4
`define MD_EXT_BIT       0
`define MD_SEP_BIT       1
`define PROT_LAST8_BIT   4
`define DESC_MS_LSB      0
`define DESC_DSIZE_LSB   16
`define DESC_MASK        32'h00ff_ffff
// ==========================================================
// Values
`define RST_WORD         32'h0000_0000
`define ADV_MIN_DSIZE    8'h0c
`define ADV_MIN_MS       16'h0008
`endif

/* ns_fmt_pkg.sv */
// Purpose: Types shared by the namespace format registers
// Assumes: Nothing
// Notes:   Constants live in ns_fmt_defines.svh
package ns_fmt_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'h0,
        RESP_SLVERR = 2'h2,
        RESP_DECERR = 2'h3
    } axi_resp_t;
endpackage

/* ns_fmt_regs.sv */
// Purpose: Namespace format and capability descriptor behind an AXI4-Lite slave
// Assumes: Alloc and dealloc pulses come from logic on clk
// Notes:   Descriptor words are read only; firmware sets them up via config words
// Functional notes
// (RULE1) Thin provisioning lets capacity sit below size; deallocations lower utilization. Code lowers it only when config feature bit 8 is also set.
// (RULE2) Without thin provisioning capacity reads exactly the size.
// (RULE3) Format count is zero based, at most sixteen formats, packed from zero.
// (RULE4) Descriptors above the format count read as invalid, all zero.
// (RULE5) A valid but unavailable format may show data size zero.
// (RULE6) Metadata goes wholly extended or wholly separate, never split.
// (RULE7) Prefer 4 KiB blocks and at least eight metadata bytes.
// (RULE8) Select bit 4 set means extended block; clear means separate buffer.
// (RULE9) Select bits 3:0 pick the format; bits 7:5 read zero.
// (RULE10) Metadata capability bit 1 means separate buffer supported; 7:2 reserved.
// (RULE11) Metadata capability bit 0 means extended block supported.
// (RULE12) Protection capability bits may combine; bits 7:5 reserved.
// (RULE13) Protection bit 4 means protection info in last eight metadata bytes.
// (RULE14) Capacity never above size, utilization never above capacity.
// (RULE15) Descriptor words are read only; reserved bits read zero.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ns_fmt_defines.svh"

module ns_fmt_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // AXI4-Lite write address
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // Block usage events
    input  wire logic        alloc_pulse,
    input  wire logic        dealloc_pulse
);

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);

    // ==========================================================
    // Decode helpers
    function automatic ns_fmt_pkg::word_t merge(
        input ns_fmt_pkg::word_t old_w,
        input ns_fmt_pkg::word_t new_w,
        input logic [3:0]        be
    );
        merge = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                merge[8*b +: 8] = new_w[8*b +: 8];
            end
        end
    endfunction

    function automatic logic writable(input logic [6:0] i);
        writable = (i >= `IDX_CFG_SIZE && i <= `IDX_CFG_PROT) || (i[6:4] == `TBL_WR_BASE);
    endfunction

    function automatic logic mapped(input logic [6:0] i);
        mapped = writable(i) || i == `IDX_NS_SIZE || i == `IDX_NS_CAP || i == `IDX_NS_USE
              || (i >= `IDX_FEAT && i <= `IDX_ADVICE) || (i[6:4] == `TBL_RD_BASE);
    endfunction

    // ==========================================================
    // Storage
    ns_fmt_pkg::word_t  cfg_size_q;
    ns_fmt_pkg::word_t  cfg_cap_q;
    ns_fmt_pkg::word_t  cfg_feat_q;
    ns_fmt_pkg::word_t  cfg_fmt_q;
    ns_fmt_pkg::word_t  cfg_md_q;
    ns_fmt_pkg::word_t  cfg_prot_q;
    ns_fmt_pkg::word_t  table_q [16];
    ns_fmt_pkg::word_t  tbl_view [16];
    ns_fmt_pkg::word_t  use_q;
    ns_fmt_pkg::word_t  use_d;

    // ==========================================================
    // Write channel
    logic                   aw_held_q;
    logic                   w_held_q;
    logic [11:0]            awaddr_q;
    ns_fmt_pkg::word_t      wdata_q;
    logic [3:0]             wstrb_q;
    logic                   bvalid_q;
    ns_fmt_pkg::axi_resp_t  bresp_q;

    wire       do_write   = aw_held_q && w_held_q;
    wire [6:0] w_idx      = awaddr_q[8:2];
    wire       w_in_range = awaddr_q[11:9] == 3'h0;
    wire       w_ok       = w_in_range && writable(w_idx);
    wire       w_map      = w_in_range && mapped(w_idx);
    wire       wr_cfg     = do_write && w_ok;

    assign s_awready = !aw_held_q && !bvalid_q;
    assign s_wready  = !w_held_q && !bvalid_q;
    assign s_bvalid  = bvalid_q;
    assign s_bresp   = bresp_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end else if (s_awvalid && s_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            w_held_q <= 1'b0;
            wdata_q  <= `RST_WORD;
            wstrb_q  <= 4'h0;
        end else if (s_wvalid && s_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_wdata;
            wstrb_q  <= s_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // Descriptor words refuse writes with SLVERR, holes give DECERR
    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ns_fmt_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_ok  ? ns_fmt_pkg::RESP_OKAY :
                        w_map ? ns_fmt_pkg::RESP_SLVERR : ns_fmt_pkg::RESP_DECERR; // [RULE15]
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration words
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_size_q <= `RST_WORD;
            cfg_cap_q  <= `RST_WORD;
            cfg_feat_q <= `RST_WORD;
            cfg_fmt_q  <= `RST_WORD;
            cfg_md_q   <= `RST_WORD;
            cfg_prot_q <= `RST_WORD;
        end else if (wr_cfg) begin
            if (w_idx == `IDX_CFG_SIZE) cfg_size_q <= merge(cfg_size_q, wdata_q, wstrb_q);
            if (w_idx == `IDX_CFG_CAP)  cfg_cap_q  <= merge(cfg_cap_q, wdata_q, wstrb_q);
            if (w_idx == `IDX_CFG_FEAT) cfg_feat_q <= merge(cfg_feat_q, wdata_q, wstrb_q);
            if (w_idx == `IDX_CFG_FMT)  cfg_fmt_q  <= merge(cfg_fmt_q, wdata_q, wstrb_q);
            if (w_idx == `IDX_CFG_MD)   cfg_md_q   <= merge(cfg_md_q, wdata_q, wstrb_q);
            if (w_idx == `IDX_CFG_PROT) cfg_prot_q <= merge(cfg_prot_q, wdata_q, wstrb_q);
        end
    end

    // ==========================================================
    // Capacity and utilization
    wire thin       = cfg_feat_q[`FEAT_THIN_BIT];
    wire dealloc_en = cfg_feat_q[`CFG_DEALLOC_BIT];
    wire [31:0] cap_clamp = (cfg_cap_q > cfg_size_q) ? cfg_size_q : cfg_cap_q; // [RULE14]
    wire [31:0] cap_rd    = thin ? cap_clamp : cfg_size_q;                  // [RULE1] [RULE2]
    wire [31:0] use_rd    = (use_q > cap_rd) ? cap_rd : use_q;              // [RULE14]

    // Counter saturates at capacity; a shrunk capacity is hidden by the clamp
    wire use_inc = alloc_pulse && (use_q < cap_rd);
    wire use_dec = dealloc_pulse && thin && dealloc_en && (use_q != `RST_WORD); // [RULE1]

    assign use_d = (use_inc && !use_dec) ? use_q + 32'h1 :
                   (use_dec && !use_inc) ? use_q - 32'h1 : use_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            use_q <= `RST_WORD;
        end else begin
            use_q <= use_d;
        end
    end

    // ==========================================================
    // Format table and selection
    wire [3:0] fmt_count = cfg_fmt_q[`CFG_FMT_CNT_LSB +: 4];   // [RULE3]
    wire [3:0] sel_raw   = cfg_fmt_q[`CFG_FMT_SEL_LSB +: 4];
    wire [3:0] sel_rd    = (sel_raw <= fmt_count) ? sel_raw : 4'h0; // [RULE9]

    for (genvar e = 0; e < 16; e++) begin : g_tbl
        wire wr_e = wr_cfg && (w_idx == {`TBL_WR_BASE, 4'(e)});
        always_ff @(posedge clk) begin
            if (srst) begin
                table_q[e] <= `RST_WORD;
            end else if (wr_e) begin
                table_q[e] <= merge(table_q[e], wdata_q, wstrb_q);
            end
        end
        // Data size zero passes through to flag an unavailable format [RULE5]
        assign tbl_view[e] = (4'(e) <= fmt_count) ? (table_q[e] & `DESC_MASK)
                                                   : `RST_WORD; // [RULE4]
    end

    ns_fmt_pkg::word_t sel_entry;
    assign sel_entry = table_q[sel_rd];
    wire [15:0] sel_ms    = sel_entry[`DESC_MS_LSB +: 16];
    wire [7:0]  sel_dsize = sel_entry[`DESC_DSIZE_LSB +: 8];
    wire        has_md    = sel_ms != 16'h0000;

    // One transfer mode only; extended needs capability bit 0, otherwise separate is reported even if not offered
    wire cap_ext = cfg_md_q[`MD_EXT_BIT];
    wire cap_sep = cfg_md_q[`MD_SEP_BIT];
    wire ext_rd  = has_md && cap_ext
                && (cfg_fmt_q[`CFG_FMT_EXT_BIT] || !cap_sep); // [RULE6] [RULE8]

    // Advisory only: software decides, the block just reports
    wire adv_dsize = sel_dsize >= `ADV_MIN_DSIZE;            // [RULE7]
    wire adv_ms    = !has_md || (sel_ms >= `ADV_MIN_MS);     // [RULE7]

    // ==========================================================
    // Read-only descriptor bytes
    wire [31:0] feat_word  = {28'h0, cfg_feat_q[3:0]};
    wire [31:0] count_word = {28'h0, fmt_count};                          // [RULE3]
    wire [31:0] sel_word   = {27'h0, ext_rd, sel_rd};                     // [RULE8] [RULE9]
    wire [31:0] md_word    = {30'h0, cap_sep, cap_ext};                   // [RULE10] [RULE11]
    wire [31:0] prot_word  = {27'h0, cfg_prot_q[4:0]};                    // [RULE12] [RULE13]
    wire [31:0] adv_word   = {30'h0, adv_ms, adv_dsize};

    // ==========================================================
    // Read channel
    logic                   rvalid_q;
    ns_fmt_pkg::word_t      rdata_q;
    ns_fmt_pkg::axi_resp_t  rresp_q;

    wire [6:0] r_idx      = s_araddr[8:2];
    wire       r_in_range = s_araddr[11:9] == 3'h0;
    wire       r_map      = r_in_range && mapped(r_idx);
    wire       ar_take    = s_arvalid && s_arready;

    wire h_size  = r_in_range && r_idx == `IDX_NS_SIZE;
    wire h_cap   = r_in_range && r_idx == `IDX_NS_CAP;
    wire h_use   = r_in_range && r_idx == `IDX_NS_USE;
    wire h_feat  = r_in_range && r_idx == `IDX_FEAT;
    wire h_count = r_in_range && r_idx == `IDX_FMT_COUNT;
    wire h_sel   = r_in_range && r_idx == `IDX_FMT_SEL;
    wire h_md    = r_in_range && r_idx == `IDX_MD_CAP;
    wire h_prot  = r_in_range && r_idx == `IDX_PROT_CAP;
    wire h_adv   = r_in_range && r_idx == `IDX_ADVICE;
    wire h_tbl   = r_in_range && r_idx[6:4] == `TBL_RD_BASE;
    wire h_twr   = r_in_range && r_idx[6:4] == `TBL_WR_BASE;
    wire h_csize = r_in_range && r_idx == `IDX_CFG_SIZE;
    wire h_ccap  = r_in_range && r_idx == `IDX_CFG_CAP;
    wire h_cfeat = r_in_range && r_idx == `IDX_CFG_FEAT;
    wire h_cfmt  = r_in_range && r_idx == `IDX_CFG_FMT;
    wire h_cmd   = r_in_range && r_idx == `IDX_CFG_MD;
    wire h_cprot = r_in_range && r_idx == `IDX_CFG_PROT;

    wire [31:0] rd_word =
          ({32{h_size}}  & cfg_size_q) | ({32{h_cap}}   & cap_rd)
        | ({32{h_use}}   & use_rd)     | ({32{h_feat}}  & feat_word)
        | ({32{h_count}} & count_word) | ({32{h_sel}}   & sel_word)
        | ({32{h_md}}    & md_word)    | ({32{h_prot}}  & prot_word)
        | ({32{h_adv}}   & adv_word)   | ({32{h_tbl}}   & tbl_view[r_idx[3:0]])
        | ({32{h_twr}}   & table_q[r_idx[3:0]])
        | ({32{h_csize}} & cfg_size_q) | ({32{h_ccap}}  & cfg_cap_q)
        | ({32{h_cfeat}} & cfg_feat_q) | ({32{h_cfmt}}  & cfg_fmt_q)
        | ({32{h_cmd}}   & cfg_md_q)   | ({32{h_cprot}} & cfg_prot_q);

    assign s_arready = !rvalid_q;
    assign s_rvalid  = rvalid_q;
    assign s_rdata   = rdata_q;
    assign s_rresp   = rresp_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= `RST_WORD;
            rresp_q  <= ns_fmt_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= r_map ? ns_fmt_pkg::RESP_OKAY : ns_fmt_pkg::RESP_DECERR;
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    a_cap_equal_size: assert property ( // [RULE2]
        ar_take && h_cap && !thin |=> rdata_q == $past(cfg_size_q))
        else $error("capacity differs from size without thin provisioning");

    a_cap_use_bound: assert property ( // [RULE14]
        ar_take && h_use |=> rdata_q <= $past(cap_rd) && $past(cap_rd) <= $past(cfg_size_q))
        else $error("utilization or capacity out of bound");

    a_dealloc_count: assert property ( // [RULE1]
        use_dec && !use_inc |=> use_q == $past(use_q) - 32'h1)
        else $error("deallocation not reflected in utilization");

    a_count_width: assert property ( // [RULE3]
        ar_take && h_count |=> rdata_q[31:4] == 28'h0 && rdata_q[3:0] == $past(fmt_count))
        else $error("format count malformed");

    a_table_invalid: assert property ( // [RULE4]
        ar_take && h_tbl && (r_idx[3:0] > fmt_count) |=> rdata_q == `RST_WORD)
        else $error("descriptor beyond format count not zero");

    a_sel_field: assert property ( // [RULE9]
        ar_take && h_sel |=> rdata_q[31:5] == 27'h0 && rdata_q[3:0] <= $past(fmt_count))
        else $error("formatted select malformed");

    a_md_one_mode: assert property ( // [RULE6] [RULE8]
        ar_take && h_sel && !(has_md && cap_ext) |=> !rdata_q[4])
        else $error("metadata mode not backed by capability");

    a_md_cap_field: assert property ( // [RULE10] [RULE11]
        ar_take && h_md |=> rdata_q[31:2] == 30'h0 && rdata_q[1:0] == $past(cfg_md_q[1:0]))
        else $error("metadata capability malformed");

    a_prot_field: assert property ( // [RULE12] [RULE13]
        ar_take && h_prot |=> rdata_q[31:5] == 27'h0 && rdata_q[4] == $past(cfg_prot_q[4]))
        else $error("protection capability malformed");

    a_ro_refused: assert property ( // [RULE15]
        do_write && w_map && !w_ok |=> bvalid_q && bresp_q == ns_fmt_pkg::RESP_SLVERR)
        else $error("write to read-only word not refused");

    a_rdata_hold: assert property (
        rvalid_q && !s_rready |=> rvalid_q && $stable(rdata_q))
        else $error("read data changed before taken");

endmodule

`default_nettype wire

/* host_model.sv */
// Purpose: Host side bus master that issues requests to the namespace format registers
// Assumes: One clock; every request starts just after a rising edge
// Notes:   Waits are unbounded, so the bench watchdog ends any hang
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // Clock
    input  wire logic        clk,
    // Write address and data
    output var logic [11:0]  awaddr,
    output var logic         awvalid,
    input  wire logic        awready,
    output var logic [31:0]  wdata,
    output var logic [3:0]   wstrb,
    output var logic         wvalid,
    input  wire logic        wready,
    // Write response
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output var logic         bready,
    // Read address and data
    output var logic [11:0]  araddr,
    output var logic         arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var logic         rready
);
    initial begin
        awaddr  = 12'h000;
        awvalid = 1'b0;
        wdata   = 32'h0000_0000;
        wstrb   = 4'h0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        araddr  = 12'h000;
        arvalid = 1'b0;
        rready  = 1'b0;
    end

    // ==========================================================
    // Write: address and data offered together, released one by one
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_done = 1'b0;
        logic w_done  = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
                // Released lines must not keep a stale but valid-looking value
                awaddr  <= ~a;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
        end
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    // ==========================================================
    // Read: one outstanding request
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        araddr  <= ~a;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the namespace format registers
// Assumes: Host model drives the register bus; bench drives usage events
// Notes:   Expected values worked out here, never read back from the design
`timescale 1ns/10ps
`default_nettype none
`include "ns_fmt_defines.svh"

module tb;
    logic              clk;
    logic              srst;
    logic              alloc_pulse;
    logic              dealloc_pulse;
    wire logic [11:0]  awaddr, araddr;
    wire logic [31:0]  wdata, rdata;
    wire logic [3:0]   wstrb;
    wire logic [1:0]   bresp, rresp;
    wire logic         awvalid, awready, wvalid, wready, bvalid, bready;
    wire logic         arvalid, arready, rvalid, rready;
    int                bad_count = 0;
    int                n_checks = 0;
    localparam logic [1:0] OK = ns_fmt_pkg::RESP_OKAY;
    localparam logic [1:0] SE = ns_fmt_pkg::RESP_SLVERR;
    logic [6:0]  ro_idx [8] = '{`IDX_NS_SIZE, `IDX_NS_CAP, `IDX_NS_USE, `IDX_FMT_COUNT,
                                `IDX_FMT_SEL, `IDX_MD_CAP, `IDX_PROT_CAP, 7'h20};
    logic [31:0] tbl [4] = '{32'hab0c_0008, 32'h0009_0000, 32'h0000_0010, 32'h000c_0008};
    logic [31:0] s_fmt [7] = '{32'h0000_0002, 32'h0001_0002, 32'h0001_0002, 32'h0000_0002,
                               32'h0001_0102, 32'h0000_0502, 32'h0001_0f0f};
    logic [31:0] s_md [7] = '{32'h1, 32'h2, 32'h3, 32'h3, 32'h3, 32'h3, 32'h3};
    logic [31:0] s_exp [7] = '{32'h10, 32'h00, 32'h10, 32'h00, 32'h01, 32'h00, 32'h0f};

    ns_fmt_regs dut (
        .clk(clk), .srst(srst),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .alloc_pulse(alloc_pulse), .dealloc_pulse(dealloc_pulse)
    );

    host_model host (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Compare and access helpers
    function automatic logic [11:0] ba(input logic [6:0] i);
        return {3'h0, i, 2'h0};
    endfunction

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic [6:0] i, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        logic [1:0] r;
        host.wr(ba(i), d, s, r);
        chk_r(r, er);
    endtask

    task automatic get(input logic [6:0] i, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(ba(i), d, r);
        chk_w(d, e);
        chk_r(r, OK);
    endtask

    task automatic pulse(input logic a, input logic d, input int n);
        repeat (n) begin
            @(posedge clk);
            alloc_pulse   <= a;
            dealloc_pulse <= d;
        end
        @(posedge clk);
        alloc_pulse   <= 1'b0;
        dealloc_pulse <= 1'b0;
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        srst          = 1'b1;
        alloc_pulse   = 1'b0;
        dealloc_pulse = 1'b0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        foreach (ro_idx[k]) begin
            get(ro_idx[k], 32'h0);
            put(ro_idx[k], 32'hffff_ffff, 4'hf, SE);
            get(ro_idx[k], 32'h0);
        end
        host.wr(12'h200, 32'h1, 4'hf, r);
        chk_r(r, ns_fmt_pkg::RESP_DECERR);
        host.rd(12'h204, d, r);
        chk_w(d, 32'h0);
        chk_r(r, ns_fmt_pkg::RESP_DECERR);
        put(`IDX_CFG_SIZE, 32'd100, 4'hf, OK);
        put(`IDX_CFG_CAP, 32'd40, 4'hf, OK);
        get(`IDX_NS_CAP, 32'd100);
        put(`IDX_CFG_FEAT, 32'h101, 4'hf, OK);
        get(`IDX_FEAT, 32'h1);
        get(`IDX_NS_CAP, 32'd40);
        put(`IDX_CFG_CAP, 32'd200, 4'hf, OK);
        get(`IDX_NS_CAP, 32'd100);
        put(`IDX_CFG_CAP, 32'd40, 4'hf, OK);
        // Allocation beyond capacity must saturate
        pulse(1'b1, 1'b0, 50);
        get(`IDX_NS_USE, 32'd40);
        pulse(1'b0, 1'b1, 5);
        get(`IDX_NS_USE, 32'd35);
        pulse(1'b1, 1'b1, 4);
        get(`IDX_NS_USE, 32'd35);
        put(`IDX_CFG_FEAT, 32'h1, 4'hf, OK);
        pulse(1'b0, 1'b1, 3);
        get(`IDX_NS_USE, 32'd35);
        put(`IDX_CFG_FEAT, 32'h0, 4'hf, OK);
        get(`IDX_NS_CAP, 32'd100);
        foreach (tbl[k]) put(7'h60 + 7'(k), tbl[k], 4'hf, OK);
        put(`IDX_CFG_FMT, 32'h2, 4'hf, OK);
        get(`IDX_FMT_COUNT, 32'h2);
        foreach (tbl[k]) begin
            get(7'h20 + 7'(k), (k <= 2) ? (tbl[k] & 32'h00ff_ffff) : 32'h0);
        end
        get(7'h2f, 32'h0);
        get(`IDX_ADVICE, 32'h3);
        put(`IDX_CFG_FMT, 32'h102, 4'hf, OK);
        get(`IDX_ADVICE, 32'h2);
        // Host never asks for split metadata: wholly extended or wholly separate
        foreach (s_fmt[k]) begin
            put(`IDX_CFG_FMT, s_fmt[k], 4'hf, OK);
            put(`IDX_CFG_MD, s_md[k], 4'hf, OK);
            get(`IDX_FMT_SEL, s_exp[k]);
        end
        get(`IDX_FMT_COUNT, 32'hf);
        put(`IDX_CFG_MD, 32'hffff_ffff, 4'hf, OK);
        get(`IDX_MD_CAP, 32'h3);
        put(`IDX_CFG_MD, 32'h0, 4'h2, OK);
        get(`IDX_MD_CAP, 32'h3);
        put(`IDX_CFG_MD, 32'h1, 4'h1, OK);
        get(`IDX_MD_CAP, 32'h1);
        put(`IDX_CFG_PROT, 32'hffff_ffff, 4'hf, OK);
        get(`IDX_PROT_CAP, 32'h1f);
        put(`IDX_CFG_PROT, 32'h10, 4'hf, OK);
        get(`IDX_PROT_CAP, 32'h10);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
